// ==== pkg/tcl_cfg.svh ====
// constants of the trip command and lamp logic
`ifndef TCL_CFG_SVH
`define TCL_CFG_SVH
`define TCL_REG_CTRL 4'h0
`define TCL_REG_LAMP_SEL0 4'h1
`define TCL_REG_LAMP_SEL1 4'h2
`define TCL_REG_STATUS 4'h3
`define TCL_REG_LAMPS 4'h4
`define TCL_CTRL_RST 32'h0000_0000
`define TCL_SEL_RST 32'h0000_0000
`define TCL_FREE_LAMPS 13
`define TCL_USER_SRCS 16
`define TCL_SEL_W 4
`define TCL_LAMP_GEN 0
`define TCL_LAMP_PHOC 1
`define TCL_LAMP_RESOC 2
`define TCL_LAMP_ARBLK 3
`define TCL_LAMP_THERM 4
`define TCL_LAMP_ARCLS 5
`define TCL_FIXED_LAMPS 6
`endif

// ==== pkg/tcl_pkg.sv ====
// types of the trip command and lamp logic
package tcl_pkg;
  typedef logic [3:0] tcl_addr_t;
  typedef logic [31:0] tcl_data_t;
endpackage

// ==== logic/tcl_trip_lamps.sv ====
// trip command combiner and front-panel lamp drivers
`timescale 1ns/100ps
`include "tcl_cfg.svh"
module tcl_trip_lamps #(
  parameter int FREE_LAMPS = `TCL_FREE_LAMPS,
  parameter int USER_SRCS = `TCL_USER_SRCS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic phase_inst_oc_trip,
  input wire logic residual_inst_oc_trip,
  input wire logic phase_time_oc_trip,
  input wire logic residual_time_oc_trip,
  input wire logic factory_trip_block,
  input wire logic user_three_phase_trip_req,
  input wire logic user_trip_block,
  input wire logic reclose_blocked,
  input wire logic thermal_alarm,
  input wire logic reclose_close_cmd,
  input wire logic [USER_SRCS-1:0] user_lamp_src,
  input wire tcl_pkg::tcl_addr_t addr,
  input wire tcl_pkg::tcl_data_t wdata,
  input wire logic wr,
  input wire logic rd,
  output logic trip_contact,
  output logic general_trip_out,
  output logic [`TCL_FIXED_LAMPS-1:0] fixed_lamp,
  output logic [FREE_LAMPS-1:0] free_lamp,
  output tcl_pkg::tcl_data_t rdata
);
  import tcl_pkg::*;

  // ------------------------------------------------
  // reset release
  // ------------------------------------------------
  logic rst_meta, rst_n;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ------------------------------------------------
  // register file
  // ------------------------------------------------
  // ctrl bit0: software trip block, bit1: software trip test request
  logic [1:0] ctrl, next_ctrl;
  logic [FREE_LAMPS*`TCL_SEL_W-1:0] sel, next_sel;
  tcl_data_t next_rdata;

  function automatic logic [`TCL_SEL_W-1:0] pick_sel(input int idx,
      input logic [FREE_LAMPS*`TCL_SEL_W-1:0] s);
    pick_sel = s[idx*`TCL_SEL_W +: `TCL_SEL_W];
  endfunction

  always_comb begin
    next_ctrl = ctrl;
    next_sel = sel;
    next_rdata = 32'h0000_0000;
    if (wr) begin
      case (addr)
        `TCL_REG_CTRL: next_ctrl = wdata[1:0];
        `TCL_REG_LAMP_SEL0: next_sel[31:0] = wdata;
        `TCL_REG_LAMP_SEL1: next_sel[FREE_LAMPS*`TCL_SEL_W-1:32] =
            wdata[FREE_LAMPS*`TCL_SEL_W-33:0];
        default: ;
      endcase
    end
    if (rd) begin
      case (addr)
        `TCL_REG_CTRL: next_rdata = {30'h0, ctrl};
        `TCL_REG_LAMP_SEL0: next_rdata = sel[31:0];
        `TCL_REG_LAMP_SEL1: next_rdata =
            {{(64-FREE_LAMPS*`TCL_SEL_W){1'b0}}, sel[FREE_LAMPS*`TCL_SEL_W-1:32]};
        `TCL_REG_STATUS: next_rdata = {30'h0, trip_contact, general_trip_out};
        `TCL_REG_LAMPS: next_rdata =
            {{(32-FREE_LAMPS-`TCL_FIXED_LAMPS){1'b0}}, free_lamp, fixed_lamp};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= 2'h0;
      sel <= '0;
      rdata <= 32'h0000_0000;
    end else if (!rst_n) begin
      ctrl <= 2'h0;
      sel <= '0;
      rdata <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      sel <= next_sel;
      rdata <= next_rdata;
    end
  end

  // ------------------------------------------------
  // trip combination
  // ------------------------------------------------
  logic factory_3ph, trip_req, blocked, next_trip;
  assign factory_3ph = phase_inst_oc_trip | residual_inst_oc_trip;
  assign trip_req = factory_3ph | user_three_phase_trip_req | ctrl[1];
  assign blocked = factory_trip_block | user_trip_block | ctrl[0];
  assign next_trip = trip_req & ~blocked;

  // ------------------------------------------------
  // lamps
  // ------------------------------------------------
  logic [`TCL_FIXED_LAMPS-1:0] next_fixed;
  logic [FREE_LAMPS-1:0] next_free;
  always_comb begin
    next_fixed = '0;
    next_fixed[`TCL_LAMP_GEN] = next_trip;
    next_fixed[`TCL_LAMP_PHOC] = phase_inst_oc_trip | phase_time_oc_trip;
    next_fixed[`TCL_LAMP_RESOC] = residual_inst_oc_trip | residual_time_oc_trip;
    next_fixed[`TCL_LAMP_ARBLK] = reclose_blocked;
    next_fixed[`TCL_LAMP_THERM] = thermal_alarm;
    next_fixed[`TCL_LAMP_ARCLS] = reclose_close_cmd;
  end

  genvar g;
  generate
    for (g = 0; g < FREE_LAMPS; g++) begin : g_free
      assign next_free[g] = user_lamp_src[pick_sel(g, sel)];
    end
  endgenerate

  // contact, general trip and general trip lamp flops share one next value so they never disagree
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      general_trip_out <= 1'b0;
      trip_contact <= 1'b0;
      fixed_lamp <= '0;
      free_lamp <= '0;
    end else if (!rst_n) begin
      general_trip_out <= 1'b0;
      trip_contact <= 1'b0;
      fixed_lamp <= '0;
      free_lamp <= '0;
    end else begin
      general_trip_out <= next_trip;
      trip_contact <= next_trip;
      fixed_lamp <= next_fixed;
      free_lamp <= next_free;
    end
  end

  // ------------------------------------------------
  // assertions
  // ------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  contact_follows_a: assert property (trip_contact == general_trip_out)
    else $error("trip contact differs from general trip");
  inst_trip_a: assert property ((phase_inst_oc_trip || residual_inst_oc_trip) && !blocked
      |=> general_trip_out)
    else $error("instantaneous trip not passed");
  user_or_a: assert property (user_three_phase_trip_req && !blocked |=> general_trip_out)
    else $error("user source not ORed");
  block_wins_a: assert property ((factory_trip_block || user_trip_block) |=> !general_trip_out)
    else $error("trip passed while blocked");
  no_cause_a: assert property (!trip_req |=> !general_trip_out)
    else $error("trip without request");
  gen_lamp_a: assert property (fixed_lamp[`TCL_LAMP_GEN] == general_trip_out)
    else $error("general trip lamp wrong");
  phase_lamp_a: assert property (phase_time_oc_trip |=> fixed_lamp[`TCL_LAMP_PHOC])
    else $error("phase lamp not lit");
  res_lamp_a: assert property (residual_time_oc_trip |=> fixed_lamp[`TCL_LAMP_RESOC])
    else $error("residual lamp not lit");
  // guard on the past reset so the first cycle after release is not judged on stale inputs
  arblk_lamp_a: assert property ($past(rst_n)
      |-> fixed_lamp[`TCL_LAMP_ARBLK] == $past(reclose_blocked))
    else $error("reclose block lamp wrong");
  therm_lamp_a: assert property ($past(rst_n)
      |-> fixed_lamp[`TCL_LAMP_THERM] == $past(thermal_alarm))
    else $error("thermal lamp wrong");
  arcls_lamp_a: assert property ($rose(reclose_close_cmd) |=> fixed_lamp[`TCL_LAMP_ARCLS])
    else $error("close lamp wrong");
  free_lamp_a: assert property ($past(rst_n)
      |-> free_lamp[0] == $past(user_lamp_src[sel[`TCL_SEL_W-1:0]]))
    else $error("free lamp source wrong");
  sw_block_a: assert property (ctrl[0] |=> !general_trip_out)
    else $error("trip passed while software block set");
  phase_inst_lamp_a: assert property (phase_inst_oc_trip |=> fixed_lamp[`TCL_LAMP_PHOC])
    else $error("phase lamp not lit on instantaneous trip");
  res_inst_lamp_a: assert property (residual_inst_oc_trip |=> fixed_lamp[`TCL_LAMP_RESOC])
    else $error("residual lamp not lit on instantaneous trip");
  rdata_idle_a: assert property (!rd |=> rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
  reset_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
      !rst_n |=> !general_trip_out && fixed_lamp == '0)
    else $error("outputs not cleared by reset");

  trip_seen_c: cover property ($rose(general_trip_out));
  blocked_trip_c: cover property (trip_req && blocked);
  free_lamp_c: cover property ($rose(free_lamp[0]));
  sw_test_c: cover property (ctrl[1] && !blocked);
  lamp_read_c: cover property (rd && addr == `TCL_REG_LAMPS);
endmodule // tcl_trip_lamps

// ==== verification/tcl_relay_led_model.sv ====
// far-side model: trip relay contact and front-panel lamps
`timescale 1ns/100ps
module tcl_relay_led_model (
  input wire logic trip_contact,
  input wire logic [18:0] lamps,
  output logic contact_closed,
  output logic [18:0] lamp_lit
);
  // ideal parts: contact bounce and lamp lag not modelled
  assign contact_closed = trip_contact;
  assign lamp_lit = lamps;
endmodule // tcl_relay_led_model

// ==== verification/trip_command_and_led_logic_tb.sv ====
// self-checking bench of the trip command and lamp logic
`timescale 1ns/100ps
module trip_command_and_led_logic_tb;
  import tcl_pkg::*;
  logic clk = 0, arst_n = 0, wr = 0, rd = 0, closed, tc, gt;
  logic [9:0] in_v = '0;
  logic [15:0] src = '0, seed = 16'hffb6;
  tcl_addr_t addr = '0;
  tcl_data_t wdata = '0, rdata, w0 = '0, w1 = '0;
  logic [5:0] fl, e;
  logic [12:0] frl;
  logic [18:0] lit;
  logic [3:0] sel [13];
  int fails = 0, n_checks = 0;
  tcl_trip_lamps DUT (.clk(clk), .arst_n(arst_n), .phase_inst_oc_trip(in_v[9]),
    .residual_inst_oc_trip(in_v[8]), .phase_time_oc_trip(in_v[7]),
    .residual_time_oc_trip(in_v[6]), .factory_trip_block(in_v[5]),
    .user_three_phase_trip_req(in_v[4]), .user_trip_block(in_v[3]),
    .reclose_blocked(in_v[2]), .thermal_alarm(in_v[1]), .reclose_close_cmd(in_v[0]),
    .user_lamp_src(src), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .trip_contact(tc), .general_trip_out(gt), .fixed_lamp(fl), .free_lamp(frl),
    .rdata(rdata));
  tcl_relay_led_model relay (.trip_contact(tc), .lamps({frl, fl}),
    .contact_closed(closed), .lamp_lit(lit));
  initial forever #25 clk = ~clk;
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // expected fixed lamps; sb is the software block bit
  function automatic logic [5:0] exp_fixed(input logic [9:0] v, input logic sb);
    return {v[0], v[1], v[2], v[8] | v[6], v[9] | v[7],
      (v[9] | v[8] | v[4]) & ~(v[5] | v[3] | sb)};
  endfunction
  function automatic logic [12:0] exp_free(input logic [15:0] s);
    logic [12:0] r;
    r = '0;
    for (int i = 0; i < 13; i++) r[i] = s[sel[i]];
    return r;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      fails++;
      $display("ERROR %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic wr_reg(input tcl_addr_t a, input tcl_data_t d);
    @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rd_chk(input tcl_addr_t a, input tcl_data_t x);
    @(posedge clk) begin addr <= a; rd <= 1'b1; end
    @(posedge clk) rd <= 1'b0;
    #1 chk(rdata, x);
  endtask
  task automatic step(input logic [9:0] v, input logic sb);
    seed = lfsr(seed);
    @(posedge clk) begin in_v <= v; src <= seed; end
    @(posedge clk);
    #1 e = exp_fixed(v, sb);
    chk(fl, e);
    chk(gt, e[0]);
    chk(closed, e[0]);
    chk(lit[0], e[0]);
    for (int i = 0; i < 13; i++) chk(frl[i], src[sel[i]]);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int a = 0; a < 5; a++) rd_chk(a[3:0], '0);
    rd_chk(4'h9, '0); // unmapped reads as zero
    for (int i = 0; i < 13; i++) begin
      seed = lfsr(seed);
      sel[i] = seed[3:0];
      if (i < 8) w0[4*i+:4] = sel[i];
      else w1[4*(i-8)+:4] = sel[i];
    end
    wr_reg(4'h1, w0);
    wr_reg(4'h2, w1);
    rd_chk(4'h1, w0);
    rd_chk(4'h2, w1);
    wr_reg(4'h0, 32'h2);
    rd_chk(4'h3, 32'h3);
    wr_reg(4'h0, '0);
    // corners: user only, user blocked, factory block, residual, time oc, lamps
    step(10'h010, 0);
    step(10'h018, 0);
    step(10'h220, 0);
    step(10'h100, 0);
    step(10'h080, 0);
    step(10'h040, 0);
    step(10'h007, 0);
    rd_chk(4'h4, {13'h0, exp_free(src), 6'h38});
    wr_reg(4'h0, 32'h1);
    step(10'h200, 1);
    rd_chk(4'h3, '0);
    wr_reg(4'h0, '0);
    step(10'h200, 0);
    rd_chk(4'h3, 32'h3);
    repeat (300) begin
      seed = lfsr(seed);
      step(seed[9:0], 0);
    end
    @(posedge clk) arst_n <= 1'b0;
    #1 chk({tc, gt, fl, frl}, '0);
    wrap_up();
  end
endmodule // trip_command_and_led_logic_tb
